// ### hdl/lpt_pkg.sv
// Shared types and constants of the link protocol timer scanner, and its
// small modulo counter. Assumes one clock domain and a byte-addressed DMA port.
`timescale 1ns/10ps

// ----------------------------------------
// Package
// ----------------------------------------
package lpt_pkg;
   localparam int LINK_W = 13;
   localparam int EXP_W = 9;
   localparam int CNT_W = 5;
   localparam int ENTRY_W = 16;
   localparam int ADDR_W = 32;
   localparam int ENT_ACTIVE_BIT = 15;
   localparam int ENT_TYPE_BIT = 14;
   localparam int ENT_CNT_LSB = 9;
   localparam int ENT_EXP_LSB = 0;
   localparam int STEP_CYCLES = 1048576;
   localparam int IDLE_STEP_MULT = 10;
   localparam int EXP_MOD = 512;
   localparam int BURST_LEN = 2;
   localparam int ENTRY_BYTES = 2;
   localparam logic [3:0] STATE_FIRST_TIMED = 4'h5;
   localparam logic [3:0] STATE_LAST_TIMED = 4'h8;
   localparam logic [ENTRY_W-1:0] ENTRY_RESET = 16'h0000;

   typedef enum logic [1:0] {
      OP_DISABLE = 2'b00,
      OP_START = 2'b01,
      OP_RESEND = 2'b10
   } lpt_op_type;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_WRITE = 3'b010,
      ST_SCAN_READ = 3'b011,
      ST_SCAN_CHECK = 3'b100
   } lpt_fsm_type;

   typedef struct packed {
      logic active;
      logic is_ack;
      logic [CNT_W-1:0] count;
      logic [EXP_W-1:0] expiry;
   } lpt_entry_type;

   typedef struct packed {
      lpt_op_type op;
      logic [LINK_W-1:0] link;
      logic is_ack;
      logic protocol;
      logic [3:0] link_state;
      logic [EXP_W-1:0] ack_period;
   } lpt_cmd_type;

   typedef struct packed {
      lpt_fsm_type fsm;
      lpt_cmd_type cmd;
      logic cmd_ready;
      logic mem_req;
      logic mem_we;
      logic mem_burst;
      logic [ADDR_W-1:0] mem_addr;
      logic [ENTRY_W-1:0] mem_wdata;
      logic beat;
      logic slot;
      lpt_entry_type ent0;
      lpt_entry_type ent1;
      logic [LINK_W-1:0] scan_link;
      logic pend_ack;
      logic pend_idle;
      logic scan_ack;
      logic scan_idle;
      logic [LINK_W-1:0] highest;
      logic expired_valid;
      logic [LINK_W-1:0] expired_link;
      logic expired_is_ack;
      logic limit_valid;
      logic limit_reached;
      logic [LINK_W-1:0] limit_link;
   } lpt_state_type;
endpackage : lpt_pkg

// ----------------------------------------
// Modulo counter
// ----------------------------------------
module lpt_mod_counter #(
   parameter int W = 9,
   parameter int MOD = 512
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Count control
   input wire logic inc,
   output logic [W-1:0] count,
   output logic wrap
);
   localparam logic [W-1:0] LAST = W'(MOD - 1);
   logic [W-1:0] next_count;

   always_comb begin
      next_count = count;
      if (inc) begin
         next_count = (count == LAST) ? '0 : W'(count + 1'b1);
      end
   end

   assign wrap = inc && (count == LAST);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else if (clk_en) begin
         count <= next_count;
      end
   end
endmodule : lpt_mod_counter

// ### hdl/lpt_timer_scan.sv
// Per-link protocol timer engine: starts, stops and scans timer entries
// held in a table in host memory. Assumes a single-beat or two-beat DMA port
// on core_clk, 16-bit data, one mem_ack per beat.
//
// Summary of operation
// - Entry bits 8-0 hold expiry time in units of matching counter.
// - Three operations: disable timer, start or restart timer, recognise timeouts.
// - Disable or start completes within three memory cycles.
// - Disable clears active flag in the link's entry.
// - Start writes counter plus period, type, zero count, active set.
// - Idle period is global; acknowledgement period comes per link.
// - Scan each step: ack step 2^20 cycles, idle step ten times longer.
// - Scan reads active entries; expiry equal to counter means expired.
// - Resend increments count by one and compares with maximum limit.
// - Track highest assigned link; scan only up to it.
// - Scan fetches two entries per memory burst.
// - Expiry may be seen up to almost one step early.
// - Entry: bit 15 active, bit 14 ack type, bits 13-9 resend count.
// - Table at host base, indexed by link identifier times two.
// - Timers only for protocol links in states 5 to 8; one per link.

`timescale 1ns/10ps
module lpt_timer_scan import lpt_pkg::*; #(
   parameter int STEP_LEN = STEP_CYCLES
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Configuration
   input wire logic [ADDR_W-1:0] table_base,
   input wire logic [EXP_W-1:0] idle_timer_period,
   input wire logic [CNT_W-1:0] max_resend_limit,
   // Link assignment
   input wire logic assign_valid,
   input wire logic [LINK_W-1:0] assign_link,
   // Operation requests
   input wire logic cmd_valid,
   input wire lpt_cmd_type cmd_in,
   output logic cmd_ready,
   // Memory master
   output logic mem_req,
   output logic mem_we,
   output logic mem_burst,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [ENTRY_W-1:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [ENTRY_W-1:0] mem_rdata,
   // Reports
   output logic expired_valid,
   output logic [LINK_W-1:0] expired_link,
   output logic expired_is_ack,
   output logic limit_valid,
   output logic limit_reached,
   output logic [LINK_W-1:0] limit_link,
   output logic [LINK_W-1:0] highest_link
);
   // ----------------------------------------
   // Step counters
   // ----------------------------------------
   logic [19:0] pre_count;
   logic ack_tick;
   logic [3:0] dec_count;
   logic dec_wrap;
   logic idle_tick;
   logic [EXP_W-1:0] ack_time;
   logic [EXP_W-1:0] idle_time;

   lpt_mod_counter #(.W(20), .MOD(STEP_LEN)) u_prescale (
      .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .inc(1'b1), .count(pre_count), .wrap(ack_tick));
   lpt_mod_counter #(.W(4), .MOD(IDLE_STEP_MULT)) u_decade (
      .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .inc(ack_tick), .count(dec_count), .wrap(dec_wrap));
   assign idle_tick = dec_wrap;
   lpt_mod_counter #(.W(EXP_W), .MOD(EXP_MOD)) u_ack_time (
      .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .inc(ack_tick), .count(ack_time), .wrap());
   lpt_mod_counter #(.W(EXP_W), .MOD(EXP_MOD)) u_idle_time (
      .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .inc(idle_tick), .count(idle_time), .wrap());

   // ----------------------------------------
   // Engine state
   // ----------------------------------------
   lpt_state_type r;
   lpt_state_type next_r;
   lpt_entry_type rd_ent;
   lpt_entry_type chk_ent;
   logic [LINK_W-1:0] chk_link;
   logic chk_hit;
   logic eligible;
   logic [CNT_W-1:0] new_count;

   function automatic logic [ADDR_W-1:0] entry_addr(input logic [ADDR_W-1:0] base,
                                                      input logic [LINK_W-1:0] link);
      entry_addr = base + ADDR_W'({link, 1'b0});
   endfunction : entry_addr

   always_comb begin
      next_r = r;
      rd_ent = lpt_entry_type'(mem_rdata);
      chk_ent = r.slot ? r.ent1 : r.ent0;
      chk_link = r.scan_link + LINK_W'(r.slot);
      chk_hit = chk_ent.active && (chk_link <= r.highest) &&
                ((chk_ent.is_ack && r.scan_ack && chk_ent.expiry == ack_time) ||
                 (!chk_ent.is_ack && r.scan_idle && chk_ent.expiry == idle_time));
      eligible = cmd_in.protocol && cmd_in.link_state >= STATE_FIRST_TIMED &&
                 cmd_in.link_state <= STATE_LAST_TIMED;
      new_count = rd_ent.count + 1'b1;
      next_r.expired_valid = 1'b0;
      next_r.limit_valid = 1'b0;
      next_r.pend_ack = r.pend_ack | ack_tick;
      next_r.pend_idle = r.pend_idle | idle_tick;
      if (assign_valid && assign_link > r.highest) begin
         next_r.highest = assign_link;
      end
      case (r.fsm)
         ST_IDLE: begin
            if (cmd_valid && r.cmd_ready) begin
               next_r.cmd = cmd_in;
               next_r.cmd_ready = 1'b0;
               next_r.mem_req = 1'b1;
               next_r.mem_burst = 1'b0;
               next_r.mem_addr = entry_addr(table_base, cmd_in.link);
               if (cmd_in.op == OP_START && eligible) begin
                  next_r.mem_we = 1'b1;
                  next_r.mem_wdata = {1'b1, cmd_in.is_ack, CNT_W'(0),
                     cmd_in.is_ack ? EXP_W'(ack_time + cmd_in.ack_period)
                                   : EXP_W'(idle_time + idle_timer_period)};
                  next_r.fsm = ST_WRITE;
               end else begin
                  next_r.cmd.op = (cmd_in.op == OP_RESEND) ? OP_RESEND : OP_DISABLE;
                  next_r.mem_we = 1'b0;
                  next_r.fsm = ST_READ;
               end
            end else if (r.pend_ack || r.pend_idle) begin
               next_r.cmd_ready = 1'b0;
               next_r.scan_ack = r.pend_ack;
               next_r.scan_idle = r.pend_idle;
               next_r.pend_ack = ack_tick;
               next_r.pend_idle = idle_tick;
               next_r.scan_link = '0;
               next_r.beat = 1'b0;
               next_r.mem_req = 1'b1;
               next_r.mem_we = 1'b0;
               next_r.mem_burst = 1'b1;
               next_r.mem_addr = entry_addr(table_base, '0);
               next_r.fsm = ST_SCAN_READ;
            end
         end
         ST_READ: begin
            if (mem_ack) begin
               next_r.mem_req = 1'b1;
               next_r.mem_we = 1'b1;
               next_r.fsm = ST_WRITE;
               if (r.cmd.op == OP_DISABLE) begin
                  next_r.mem_wdata = mem_rdata & ~(ENTRY_W'(1) << ENT_ACTIVE_BIT);
               end else if (rd_ent.active) begin
                  next_r.mem_wdata = {rd_ent.active, rd_ent.is_ack, new_count, rd_ent.expiry};
                  next_r.limit_valid = 1'b1;
                  next_r.limit_reached = new_count >= max_resend_limit;
                  next_r.limit_link = r.cmd.link;
               end else begin
                  next_r.mem_req = 1'b0;
                  next_r.mem_we = 1'b0;
                  next_r.cmd_ready = 1'b1;
                  next_r.fsm = ST_IDLE;
               end
            end
         end
         ST_WRITE: begin
            if (mem_ack) begin
               next_r.mem_req = 1'b0;
               next_r.mem_we = 1'b0;
               next_r.cmd_ready = 1'b1;
               next_r.fsm = ST_IDLE;
            end
         end
         ST_SCAN_READ: begin
            if (mem_ack) begin
               next_r.beat = ~r.beat;
               if (!r.beat) begin
                  next_r.ent0 = rd_ent;
               end else begin
                  next_r.ent1 = rd_ent;
                  next_r.mem_req = 1'b0;
                  next_r.mem_burst = 1'b0;
                  next_r.slot = 1'b0;
                  next_r.fsm = ST_SCAN_CHECK;
               end
            end
         end
         ST_SCAN_CHECK: begin
            if (chk_hit) begin
               next_r.expired_valid = 1'b1;
               next_r.expired_link = chk_link;
               next_r.expired_is_ack = chk_ent.is_ack;
            end
            next_r.slot = ~r.slot;
            if (r.slot) begin
               if ({1'b0, r.scan_link} + 14'(BURST_LEN) > {1'b0, r.highest}) begin
                  next_r.cmd_ready = 1'b1;
                  next_r.fsm = ST_IDLE;
               end else begin
                  next_r.scan_link = LINK_W'(r.scan_link + LINK_W'(BURST_LEN));
                  next_r.beat = 1'b0;
                  next_r.mem_req = 1'b1;
                  next_r.mem_burst = 1'b1;
                  next_r.mem_addr = entry_addr(table_base, LINK_W'(r.scan_link + LINK_W'(BURST_LEN)));
                  next_r.fsm = ST_SCAN_READ;
               end
            end
         end
         default: begin
            next_r.fsm = ST_IDLE;
            next_r.cmd_ready = 1'b1;
            next_r.mem_req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.cmd_ready <= 1'b1;
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   assign cmd_ready = r.cmd_ready;
   assign mem_req = r.mem_req;
   assign mem_we = r.mem_we;
   assign mem_burst = r.mem_burst;
   assign mem_addr = r.mem_addr;
   assign mem_wdata = r.mem_wdata;
   assign expired_valid = r.expired_valid;
   assign expired_link = r.expired_link;
   assign expired_is_ack = r.expired_is_ack;
   assign limit_valid = r.limit_valid;
   assign limit_reached = r.limit_reached;
   assign limit_link = r.limit_link;
   assign highest_link = r.highest;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_start_write;
      @(posedge core_clk) disable iff (!resetn)
      (clk_en && cmd_valid && cmd_ready && cmd_in.op == OP_START && eligible) |=>
         (mem_we && mem_wdata[ENT_ACTIVE_BIT] && mem_wdata[13:9] == 5'h00);
   endproperty
   a_start_write: assert property (p_start_write) else $error("start entry malformed");

   property p_disable_clear;
      @(posedge core_clk) disable iff (!resetn)
      (mem_req && mem_we && r.cmd.op == OP_DISABLE) |-> !mem_wdata[ENT_ACTIVE_BIT];
   endproperty
   a_disable_clear: assert property (p_disable_clear) else $error("disable left entry active");

   property p_op_cycles;
      @(posedge core_clk) disable iff (!resetn)
      (r.fsm == ST_READ && mem_ack && clk_en) |=> (r.fsm == ST_WRITE || r.fsm == ST_IDLE);
   endproperty
   a_op_cycles: assert property (p_op_cycles) else $error("operation exceeds memory cycles");

   property p_burst_read;
      @(posedge core_clk) disable iff (!resetn)
      mem_burst |-> (mem_req && !mem_we && !mem_addr[1]);
   endproperty
   a_burst_read: assert property (p_burst_read) else $error("scan burst not an aligned read");

   property p_report_bound;
      @(posedge core_clk) disable iff (!resetn)
      expired_valid |-> (expired_link <= highest_link && $past(chk_ent.active));
   endproperty
   a_report_bound: assert property (p_report_bound) else $error("bad expiry report");

   property p_resend_inc;
      @(posedge core_clk) disable iff (!resetn)
      limit_valid |-> (mem_wdata[13:9] == 5'($past(mem_rdata[13:9]) + 1'b1)
                      && limit_reached == (mem_wdata[13:9] >= max_resend_limit));
   endproperty
   a_resend_inc: assert property (p_resend_inc) else $error("resend count not incremented");

   property p_idle_step;
      @(posedge core_clk) disable iff (!resetn)
      idle_tick |-> ack_tick && dec_count == 4'h9;
   endproperty
   a_idle_step: assert property (p_idle_step) else $error("idle step not ten ack steps");

   property p_scan_starts;
      @(posedge core_clk) disable iff (!resetn)
      (clk_en && r.fsm == ST_IDLE && !cmd_valid && (r.pend_ack || r.pend_idle)) |=>
         (r.fsm == ST_SCAN_READ && mem_addr == table_base && mem_burst);
   endproperty
   a_scan_starts: assert property (p_scan_starts) else $error("pass not started at table base");

   property p_highest;
      @(posedge core_clk) disable iff (!resetn)
      (clk_en && assign_valid) |=> highest_link >= $past(assign_link);
   endproperty
   a_highest: assert property (p_highest) else $error("highest link not tracked");
endmodule : lpt_timer_scan

// ### verif/lpt_mem_model.sv
// Behavioural host memory holding the timer table for the timer scanner.
// Assumes word beats of 16 bits, one mem_ack pulse per beat, pacing from slow.
`timescale 1ns/10ps
module lpt_mem_model import lpt_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Placement and pacing
   input wire logic [ADDR_W-1:0] table_base,
   input wire logic [3:0] slow,
   // Memory slave
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_burst,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [ENTRY_W-1:0] mem_wdata,
   output logic mem_ack,
   output logic [ENTRY_W-1:0] mem_rdata
);
   logic [ENTRY_W-1:0] mem [0:31];
   logic [3:0] wait_cnt;
   logic beat;
   logic [ADDR_W-1:0] idx;

   // ----------------------------------------
   // Table storage
   // ----------------------------------------
   assign idx = ((mem_addr - table_base) >> 1) + ADDR_W'(beat);
   initial begin
      for (int i = 0; i < 32; i++) begin
         mem[i] = ENTRY_RESET;
      end
   end

   // ----------------------------------------
   // Beat handling
   // ----------------------------------------
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mem_ack <= 1'b0;
         wait_cnt <= 4'h0;
         beat <= 1'b0;
         mem_rdata <= 16'hA5A5;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         wait_cnt <= 4'h0;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req && wait_cnt >= slow) begin
         mem_ack <= 1'b1;
         beat <= mem_burst && !beat;
         if (mem_we) begin
            mem[idx[4:0]] <= mem_wdata;
         end else begin
            mem_rdata <= mem[idx[4:0]];
         end
      end else begin
         wait_cnt <= mem_req ? wait_cnt + 4'h1 : 4'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : lpt_mem_model

// ### verif/testbench.sv
// Self-checking bench for the timer scanner against the memory model.
// Assumes a short step length so that scan passes come quickly.
`timescale 1ns/10ps
module testbench import lpt_pkg::*; ;
   localparam int STEP = 128;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic [ADDR_W-1:0] table_base = 32'h00001000;
   logic [EXP_W-1:0] idle_timer_period = 9'h001;
   logic [CNT_W-1:0] max_resend_limit = 5'h02;
   logic assign_valid = 1'b0;
   logic [LINK_W-1:0] assign_link = 13'h0000;
   logic cmd_valid = 1'b0;
   lpt_cmd_type cmd_in = '0;
   logic [3:0] mem_slow = 4'h0;
   logic cmd_ready, mem_req, mem_we, mem_burst, mem_ack;
   logic [ADDR_W-1:0] mem_addr;
   logic [ENTRY_W-1:0] mem_wdata, mem_rdata, ent;
   logic expired_valid, expired_is_ack, limit_valid, limit_reached;
   logic [LINK_W-1:0] expired_link, limit_link, highest_link;
   logic [LINK_W:0] exp_q[$];
   logic [LINK_W:0] lim_q[$];
   logic [8:0] per, est0, d;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;

   lpt_timer_scan #(.STEP_LEN(STEP)) u_lpt_timer_scan (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .table_base(table_base), .idle_timer_period(idle_timer_period), .max_resend_limit(max_resend_limit),
      .assign_valid(assign_valid), .assign_link(assign_link), .cmd_valid(cmd_valid), .cmd_in(cmd_in),
      .cmd_ready(cmd_ready), .mem_req(mem_req), .mem_we(mem_we), .mem_burst(mem_burst), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .expired_valid(expired_valid),
      .expired_link(expired_link), .expired_is_ack(expired_is_ack), .limit_valid(limit_valid),
      .limit_reached(limit_reached), .limit_link(limit_link), .highest_link(highest_link));
   lpt_mem_model u_lpt_mem_model (.core_clk(core_clk), .resetn(resetn), .table_base(table_base),
      .slow(mem_slow), .mem_req(mem_req), .mem_we(mem_we), .mem_burst(mem_burst), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   initial begin
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (resetn && clk_en) cyc <= cyc + 1;
   end

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task step_wait(inout int n);
      @(negedge core_clk);
      n++;
      if (n > 4000) begin
         check("wait", 32'h0, 32'h1);
         give_verdict();
      end
   endtask : step_wait

   // ----------------------------------------
   // Report watchers
   // ----------------------------------------
   always @(negedge core_clk) begin
      if (resetn && expired_valid)
         check("expired report", {expired_link, expired_is_ack},
               exp_q.size() ? exp_q.pop_front() : 14'h3FFF);
      if (resetn && limit_valid)
         check("limit report", {limit_link, limit_reached},
               lim_q.size() ? lim_q.pop_front() : 14'h3FFF);
   end

   // ----------------------------------------
   // Drivers
   // ----------------------------------------
   task do_cmd(input lpt_op_type op, input int link, input logic ack, input logic prot, input logic [3:0] st,
               input logic [8:0] p);
      int n;
      int acks;
      n = 0;
      acks = 0;
      @(negedge core_clk);
      mem_slow = 4'($urandom_range(0, 3));
      cmd_in = '{op, link[LINK_W-1:0], ack, prot, st, p};
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) step_wait(n);
      step_wait(n);
      cmd_valid = 1'b0;
      while (cmd_ready !== 1'b1) begin
         if (mem_ack === 1'b1) acks++;
         step_wait(n);
      end
      check("memory cycles", 32'(acks <= 3), 32'h1);
   endtask : do_cmd
   task drain;
      int n;
      n = 0;
      while (exp_q.size() + lim_q.size() > 0) step_wait(n);
      check("reports drained", 32'(exp_q.size() + lim_q.size()), 32'h0);
   endtask : drain

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      void'($urandom(32'h1940));
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      resetn = 1'b1;
      check("ready after reset", cmd_ready, 32'h1);
      check("request after reset", mem_req, 32'h0);
      for (int i = 0; i <= 5; i++) begin
         @(negedge core_clk);
         assign_valid = 1'b1;
         assign_link = LINK_W'(i);
      end
      @(negedge core_clk);
      assign_valid = 1'b0;
      @(negedge core_clk);
      check("highest link", highest_link, 32'h5);
      clk_en = 1'b0;
      assign_valid = 1'b1;
      assign_link = 13'h0007;
      repeat (3) @(negedge core_clk);
      check("frozen highest link", highest_link, 32'h5);
      assign_valid = 1'b0;
      clk_en = 1'b1;
      @(negedge core_clk);
      check("highest link after freeze", highest_link, 32'h5);
      u_lpt_mem_model.mem[9] = 16'hC005;
      per = 9'($urandom_range(100, 400));
      est0 = 9'(cyc / STEP);
      do_cmd(OP_START, 0, 1'b1, 1'b1, 4'h7, per);
      ent = u_lpt_mem_model.mem[0];
      check("start fields", ent[15:9], 32'h60);
      d = ent[8:0] - per - est0;
      check("start expiry", 32'((d <= 9'(cyc / STEP) - est0 + 9'h1) || d == 9'h1FF), 32'h1);
      do_cmd(OP_DISABLE, 0, 1'b1, 1'b1, 4'h7, 9'h000);
      check("disabled entry", u_lpt_mem_model.mem[0], {1'b0, ent[14:0]});
      u_lpt_mem_model.mem[4] = 16'h8100;
      do_cmd(OP_START, 4, 1'b1, 1'b0, 4'h5, 9'h003);
      check("nonprotocol start", u_lpt_mem_model.mem[4][15], 32'h0);
      do_cmd(OP_START, 5, 1'b1, 1'b1, 4'h9, 9'h003);
      check("untimed state start", u_lpt_mem_model.mem[5][15], 32'h0);
      exp_q.push_back({13'h0002, 1'b0});
      do_cmd(OP_START, 2, 1'b0, 1'b1, 4'h6, 9'h1F0);
      check("idle entry", u_lpt_mem_model.mem[2][15:14], 32'h2);
      drain();
      for (int s = 5; s <= 8; s++) begin
         if (s == 8) exp_q.push_back({13'h0001, 1'b1});
         do_cmd(OP_START, 1, 1'b1, 1'b1, 4'(s), (s == 8) ? 9'h002 : 9'h1F0);
         check("timed state start", u_lpt_mem_model.mem[1][15:14], 32'h3);
      end
      for (int r = 1; r <= 2; r++) begin
         lim_q.push_back({13'h0001, r == 2});
         do_cmd(OP_RESEND, 1, 1'b1, 1'b1, 4'h8, 9'h000);
         check("resend count", u_lpt_mem_model.mem[1][13:9], 32'(r));
      end
      do_cmd(OP_RESEND, 0, 1'b1, 1'b1, 4'h8, 9'h000);
      drain();
      repeat (100) @(negedge core_clk);
      give_verdict();
   end
endmodule : testbench
